// file: rtl/clk_switch_pkg.sv
// Constants for the clock source switching controller
package clk_switch_pkg;
   // Source codes
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [2:0] SRC_RSVD = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV = 3'h7;
   // Status word bit positions (low byte)
   localparam int BIT_REQ = 0;
   localparam int BIT_CF = 3;
   localparam int BIT_LOCK = 5;
   // Oscillator enable vector positions
   localparam int OSC_FRC = 0;
   localparam int OSC_PRI = 1;
   localparam int OSC_SEC = 2;
   localparam int OSC_LOW_POWER_RC_OSC = 3;
   localparam int OSC_PLL = 4;
   localparam int OSC_N = 5;
   // New-clock settle count
   localparam logic [3:0] SETTLE_CYCLES = 4'ha;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [2:0] SRC_ZERO = 3'h0;
   localparam logic [OSC_N-1:0] OSC_NONE = 5'h00;
   // Switch sequence states, Gray from idle through done
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CHECK = 3'h1,
      ST_START = 3'h3,
      ST_SETTLE = 3'h2,
      ST_DONE = 3'h6
   } sw_state_e;
endpackage

// file: rtl/clock_source_switcher.sv
// Clock source switching controller with unlock-gated control bits
`timescale 1ns/100ps
`default_nettype none
// Function
// - Software selects a clock source only while no switch is in progress
// - Primary submode fixed by configuration input
// - Switching disabled unless configuration enables it
// - Disabled: new selection ignored, current from config
// - Disabled: request bit ignored, reads zero
// - Equal selections clear request, abort switch
// - Valid switch clears lock and fail flags
// - Start target oscillator; crystal waits startup
// - PLL target waits for lock first
// - Count ten new-clock cycles before changeover
// - Completion clears request, copies new selection
// - Stop old source except kept-on exceptions
// - Processor keeps running during the switch
// - Three-bit source code encoding
// - Lock status clears in non-PLL modes
// - First clock after reset loads new selection from configuration
module clock_source_switcher (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Configuration bits
   input wire logic switchCfgEn,
   input wire logic [2:0] resetOscCfg,
   input wire logic [1:0] primarySubmodeCfg,
   input wire logic watchdogEn,
   input wire logic secondaryKeepOn,
   // Software access
   input wire logic unlockHi,
   input wire logic unlockLo,
   input wire logic wrHi,
   input wire logic [2:0] wrNewOscSel,
   input wire logic wrLo,
   input wire logic wrSwitchRequest,
   input wire logic wrClearFail,
   // Oscillator status
   input wire logic startupTimerDone,
   input wire logic pllLocked,
   input wire logic newClkTick,
   input wire logic clockFailEvent,
   // Status and control outputs
   output logic [2:0] currentOscSel,
   output logic [2:0] newOscSel,
   output logic switchRequest,
   output logic clockFailFlag,
   output logic pllLockStatus,
   output logic failsafeEn,
   output logic [1:0] primarySubmode,
   output logic [clk_switch_pkg::OSC_N-1:0] oscEnable,
   output logic sysClkSelStrobe
);
   import clk_switch_pkg::*;

   // Source needs the PLL
   function automatic logic usesPll(input logic [2:0] s);
      usesPll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction

   // Oscillators that a source code needs running
   function automatic logic [OSC_N-1:0] oscNeed(input logic [2:0] s);
      oscNeed = OSC_NONE;
      case (s)
         SRC_FRC, SRC_FRC_DIV: oscNeed[OSC_FRC] = 1'b1;
         SRC_FRC_PLL: begin
            oscNeed[OSC_FRC] = 1'b1;
            oscNeed[OSC_PLL] = 1'b1;
         end
         SRC_PRI: oscNeed[OSC_PRI] = 1'b1;
         SRC_PRI_PLL: begin
            oscNeed[OSC_PRI] = 1'b1;
            oscNeed[OSC_PLL] = 1'b1;
         end
         SRC_SEC: oscNeed[OSC_SEC] = 1'b1;
         SRC_LOW_POWER_RC_OSC: oscNeed[OSC_LOW_POWER_RC_OSC] = 1'b1;
         default: oscNeed = OSC_NONE;
      endcase
   endfunction

   sw_state_e state_q, state_d;
   logic [2:0] cur_q, cur_d, nxt_q, nxt_d;
   logic req_q, req_d, cf_q, cf_d, lock_q, lock_d;
   logic unlHi_q, unlHi_d, unlLo_q, unlLo_d;
   logic [3:0] cnt_q, cnt_d;
   logic [OSC_N-1:0] en_q, en_d;
   logic strobe_q, strobe_d;
   logic [1:0] sub_q;
   logic fsm_q, fsm_d;
   logic started_q, started_d;
   logic [OSC_N-1:0] keep;
   logic [OSC_N-1:0] tgtNeed;

   // Oscillators that must stay on whatever the selection
   always_comb begin
      // Target needs kept as a vector, since a call result cannot be bit-selected
      tgtNeed = oscNeed(nxt_q);
      keep = OSC_NONE;
      keep[OSC_LOW_POWER_RC_OSC] = watchdogEn | fsm_q;
      keep[OSC_SEC] = secondaryKeepOn;
   end

   // Next-state logic for the switch sequence and control bits
   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      nxt_d = nxt_q;
      req_d = req_q;
      cf_d = cf_q | clockFailEvent;
      lock_d = pllLocked & usesPll(cur_q);
      unlHi_d = unlHi_q;
      unlLo_d = unlLo_q;
      cnt_d = cnt_q;
      en_d = en_q;
      strobe_d = 1'b0;
      fsm_d = switchCfgEn;
      started_d = 1'b1;
      // Unlock permits exactly one write per byte
      if (unlockHi) unlHi_d = 1'b1;
      if (unlockLo) unlLo_d = 1'b1;
      // Clear loses to a fresh failure event
      if (wrLo && unlLo_q && wrClearFail && !clockFailEvent) cf_d = 1'b0;
      if (wrHi && unlHi_q) begin
         unlHi_d = 1'b0;
         if (switchCfgEn && state_q == ST_IDLE) nxt_d = wrNewOscSel;
      end
      if (wrLo && unlLo_q) begin
         unlLo_d = 1'b0;
         if (switchCfgEn && wrSwitchRequest) req_d = 1'b1;
      end
      // Config-only selection until switching is enabled
      if (!switchCfgEn) begin
         req_d = 1'b0;
         cur_d = resetOscCfg;
         nxt_d = resetOscCfg;
         state_d = ST_IDLE;
         en_d = oscNeed(resetOscCfg) | keep;
      end else begin
         case (state_q)
            ST_IDLE: if (req_q) state_d = ST_CHECK;
            ST_CHECK: begin
               if (nxt_q == cur_q || nxt_q == SRC_RSVD) begin
                  req_d = 1'b0;
                  state_d = ST_IDLE;
               end else begin
                  lock_d = 1'b0;
                  cf_d = clockFailEvent;
                  en_d = en_q | oscNeed(nxt_q);
                  state_d = ST_START;
               end
            end
            ST_START: begin
               lock_d = 1'b0;
               // Crystal start and PLL lock both gate progress
               if ((!tgtNeed[OSC_PRI] || startupTimerDone)
                   && (!usesPll(nxt_q) || pllLocked)) begin
                  cnt_d = SETTLE_CYCLES;
                  state_d = ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (newClkTick) cnt_d = cnt_q - CNT_ONE;
               if (newClkTick && cnt_q == CNT_ONE) state_d = ST_DONE;
            end
            ST_DONE: begin
               req_d = 1'b0;
               cur_d = nxt_q;
               strobe_d = 1'b1;
               en_d = oscNeed(nxt_q) | keep;
               state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   // State registers; reset loads zero, selection loads from config on the first clock after reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cur_q <= SRC_ZERO;
         nxt_q <= SRC_ZERO;
         req_q <= 1'b0;
         cf_q <= 1'b0;
         lock_q <= 1'b0;
         unlHi_q <= 1'b0;
         unlLo_q <= 1'b0;
         cnt_q <= 4'h0;
         en_q <= OSC_NONE;
         strobe_q <= 1'b0;
         fsm_q <= 1'b0;
         started_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cur_q <= started_q ? cur_d : resetOscCfg;
         nxt_q <= started_q ? nxt_d : resetOscCfg;
         req_q <= req_d;
         cf_q <= cf_d;
         lock_q <= lock_d;
         unlHi_q <= unlHi_d;
         unlLo_q <= unlLo_d;
         cnt_q <= cnt_d;
         en_q <= en_d;
         strobe_q <= strobe_d;
         fsm_q <= fsm_d;
         started_q <= started_d;
      end
   end

   // Submode is latched from configuration only, never by software
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) sub_q <= 2'h0;
      else sub_q <= primarySubmodeCfg;
   end

   // Outputs straight from flip-flops; CPU never stalls here
   assign currentOscSel = cur_q;
   assign newOscSel = nxt_q;
   assign switchRequest = req_q;
   assign clockFailFlag = cf_q;
   assign pllLockStatus = lock_q;
   assign failsafeEn = fsm_q;
   assign primarySubmode = sub_q;
   assign oscEnable = en_q;
   assign sysClkSelStrobe = strobe_q;

   // Assertions
   sequence seqValidStart;
      state_q == ST_CHECK && nxt_q != cur_q && nxt_q != SRC_RSVD && switchCfgEn;
   endsequence
   AST_REQ_ZERO_DISABLED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !fsm_q |=> !req_q) else $error("request set while disabled");
   AST_REDUNDANT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_CHECK && nxt_q == cur_q && switchCfgEn) |=> !req_q && state_q == ST_IDLE)
      else $error("redundant switch not aborted");
   AST_CLEAR_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      seqValidStart |=> !lock_q) else $error("lock not cleared on switch");
   AST_PLL_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_START && usesPll(nxt_q) && !pllLocked && switchCfgEn) |=> state_q == ST_START)
      else $error("left start without lock");
   AST_SETTLE_TEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($rose(state_q == ST_SETTLE)) |-> cnt_q == SETTLE_CYCLES) else $error("settle count wrong");
   AST_COMPLETE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_DONE && switchCfgEn) |=> !req_q && cur_q == $past(nxt_q) && sysClkSelStrobe)
      else $error("completion wrong");
   AST_LOCK_NONPLL: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!usesPll(cur_q) && started_q) |=> !lock_q || usesPll($past(cur_q, 1)))
      else $error("lock set in non-PLL mode");
   AST_CURRENT_OSC_SEL_CFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!switchCfgEn && started_q) |=> cur_q == $past(resetOscCfg)) else $error("current not config");
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the clock source switching controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import clk_switch_pkg::*;
   logic sys_clk, rst_n, switchCfgEn, watchdogEn, secondaryKeepOn;
   logic [2:0] resetOscCfg, wrNewOscSel, currentOscSel, newOscSel;
   logic [1:0] primarySubmodeCfg, primarySubmode;
   logic unlockHi, unlockLo, wrHi, wrLo, wrSwitchRequest, wrClearFail;
   logic startupTimerDone, pllLocked, newClkTick, clockFailEvent;
   logic switchRequest, clockFailFlag, pllLockStatus, failsafeEn, sysClkSelStrobe;
   logic [OSC_N-1:0] oscEnable;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;

   clock_source_switcher u_clock_source_switcher (.sys_clk(sys_clk), .rst_n(rst_n), .switchCfgEn(switchCfgEn),
      .resetOscCfg(resetOscCfg), .primarySubmodeCfg(primarySubmodeCfg), .watchdogEn(watchdogEn),
      .secondaryKeepOn(secondaryKeepOn), .unlockHi(unlockHi), .unlockLo(unlockLo), .wrHi(wrHi),
      .wrNewOscSel(wrNewOscSel), .wrLo(wrLo), .wrSwitchRequest(wrSwitchRequest), .wrClearFail(wrClearFail),
      .startupTimerDone(startupTimerDone), .pllLocked(pllLocked), .newClkTick(newClkTick),
      .clockFailEvent(clockFailEvent), .currentOscSel(currentOscSel), .newOscSel(newOscSel),
      .switchRequest(switchRequest), .clockFailFlag(clockFailFlag), .pllLockStatus(pllLockStatus),
      .failsafeEn(failsafeEn), .primarySubmode(primarySubmode), .oscEnable(oscEnable),
      .sysClkSelStrobe(sysClkSelStrobe));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Hang guard, generous against the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // Reset held eight cycles; requests start well after release
   task automatic do_reset();
      rst_n = 1'b0;
      idle(8);
      rst_n = 1'b1;
      idle(3);
   endtask

   // Unlock, select, unlock, request: the software order
   task automatic sw_req(input logic [2:0] sel);
      @(negedge sys_clk) unlockHi = 1'b1;
      @(negedge sys_clk) begin
         unlockHi = 1'b0;
         wrHi = 1'b1;
         wrNewOscSel = sel;
      end
      @(negedge sys_clk) begin
         wrHi = 1'b0;
         unlockLo = 1'b1;
      end
      @(negedge sys_clk) begin
         unlockLo = 1'b0;
         wrLo = 1'b1;
         wrSwitchRequest = 1'b1;
      end
      @(negedge sys_clk) begin
         wrLo = 1'b0;
         wrSwitchRequest = 1'b0;
      end
   endtask

   // One tick per cycle of the new source
   task automatic ticks(input int n);
      repeat (n) @(negedge sys_clk) newClkTick = 1'b1;
      @(negedge sys_clk) newClkTick = 1'b0;
   endtask

   task automatic wait_strobe();
      int k;
      k = 0;
      while (sysClkSelStrobe !== 1'b1 && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      chk(8'(sysClkSelStrobe), 8'h1);
   endtask

   task automatic do_sw(input logic [2:0] sel);
      sw_req(sel);
      idle(3);
      ticks(10);
      wait_strobe();
      idle(2);
   endtask

   initial begin
      {unlockHi, unlockLo, wrHi, wrLo, wrSwitchRequest, wrClearFail, newClkTick, clockFailEvent} = 8'h00;
      {watchdogEn, secondaryKeepOn} = 2'h0;
      {switchCfgEn, startupTimerDone, pllLocked} = 3'h7;
      wrNewOscSel = SRC_ZERO;
      resetOscCfg = SRC_FRC;
      primarySubmodeCfg = 2'h1;
      rst_n = 1'b0;
      do_reset();
      chk(8'(currentOscSel), 8'(SRC_FRC));
      chk(8'(newOscSel), 8'(SRC_FRC));
      chk(8'(primarySubmode), 8'h1);
      chk(8'(failsafeEn), 8'h1);
      // A write with no unlock before it is dropped
      @(negedge sys_clk) begin
         wrHi = 1'b1;
         wrNewOscSel = SRC_PRI;
      end
      @(negedge sys_clk) wrHi = 1'b0;
      idle(2);
      chk(8'(newOscSel), 8'(SRC_FRC));
      // Redundant and reserved requests abort with request cleared and current selection unchanged
      sw_req(SRC_FRC);
      idle(5);
      chk(8'({switchRequest, currentOscSel}), 8'({1'b0, SRC_FRC}));
      sw_req(SRC_RSVD);
      idle(5);
      chk(8'({switchRequest, currentOscSel}), 8'({1'b0, SRC_FRC}));
      @(negedge sys_clk) clockFailEvent = 1'b1;
      @(negedge sys_clk) clockFailEvent = 1'b0;
      idle(1);
      chk(8'(clockFailFlag), 8'h1);
      // Primary with PLL: startup and lock both hold the switch back
      startupTimerDone = 1'b0;
      pllLocked = 1'b0;
      sw_req(SRC_PRI_PLL);
      idle(3);
      chk(8'({switchRequest, clockFailFlag, pllLockStatus}), 8'h4);
      chk(8'(oscEnable[OSC_PRI]), 8'h1);
      chk(8'(oscEnable[OSC_PLL]), 8'h1);
      ticks(12);
      chk(8'(currentOscSel), 8'(SRC_FRC));
      startupTimerDone = 1'b1;
      ticks(12);
      chk(8'(currentOscSel), 8'(SRC_FRC));
      pllLocked = 1'b1;
      idle(4);
      ticks(9);
      idle(3);
      chk(8'({switchRequest, currentOscSel}), 8'({1'b1, SRC_FRC}));
      ticks(1);
      wait_strobe();
      idle(2);
      chk(8'({switchRequest, currentOscSel}), 8'({1'b0, SRC_PRI_PLL}));
      chk(8'(pllLockStatus), 8'h1);
      chk(8'(oscEnable[OSC_FRC]), 8'h0);
      // Kept-on exceptions for the low-power RC and the secondary
      watchdogEn = 1'b1;
      secondaryKeepOn = 1'b1;
      do_sw(SRC_FRC);
      chk(8'(oscEnable[OSC_PLL]), 8'h0);
      do_sw(SRC_LOW_POWER_RC_OSC);
      chk(8'(pllLockStatus), 8'h0);
      do_sw(SRC_SEC);
      chk(8'(oscEnable[OSC_LOW_POWER_RC_OSC]), 8'h1);
      do_sw(SRC_FRC);
      chk(8'({oscEnable[OSC_SEC], currentOscSel}), 8'({1'b1, SRC_FRC}));
      // Fail flag cleared by an unlocked low-byte write, not by one without unlock
      @(negedge sys_clk) clockFailEvent = 1'b1;
      @(negedge sys_clk) begin
         clockFailEvent = 1'b0;
         unlockLo = 1'b1;
      end
      @(negedge sys_clk) begin
         unlockLo = 1'b0;
         wrLo = 1'b1;
         wrClearFail = 1'b1;
      end
      @(negedge sys_clk) begin
         wrLo = 1'b0;
         wrClearFail = 1'b0;
      end
      idle(1);
      chk(8'(clockFailFlag), 8'h0);
      @(negedge sys_clk) clockFailEvent = 1'b1;
      @(negedge sys_clk) begin
         clockFailEvent = 1'b0;
         wrLo = 1'b1;
         wrClearFail = 1'b1;
      end
      @(negedge sys_clk) begin
         wrLo = 1'b0;
         wrClearFail = 1'b0;
      end
      idle(1);
      chk(8'(clockFailFlag), 8'h1);
      // Switching disabled by configuration
      switchCfgEn = 1'b0;
      resetOscCfg = SRC_SEC;
      do_reset();
      sw_req(SRC_PRI);
      idle(1);
      chk(8'(switchRequest), 8'h0);
      idle(12);
      chk(8'({currentOscSel, failsafeEn}), 8'({SRC_SEC, 1'b0}));
      test_done();
   end
endmodule
`default_nettype wire
